// file: rtl/aosd_pkg.sv
// Shared constants and types for the analog output block
package aosd_pkg;
  // Range codes
  localparam logic [7:0] RANGE_WIDE = 8'h10;
  localparam logic [7:0] RANGE_NARR = 8'h20;
  localparam logic [7:0] RANGE_OFF  = 8'hff;
  // Accepted maximum and nominal words
  localparam logic [15:0] WIDE_MAX = 16'h7eff;
  localparam logic [15:0] WIDE_NOM = 16'h6c00;
  localparam logic [15:0] NARR_MAX = 16'h5000;
  localparam logic [15:0] NARR_NOM = 16'h4000;
  // DAC full scale is 12.5 V; gain is 2^16*3276/nominal
  localparam int          DAC_W    = 12;
  localparam logic [15:0] WIDE_GAIN = 16'h1e55;
  localparam logic [15:0] NARR_GAIN = 16'h3330;
  localparam int          GAIN_SH   = 16;
  // Microsecond tick from the 10 MHz clock
  localparam int          CLK_HZ    = 10_000_000;
  localparam int          TICK_HZ   = 1_000_000;
  localparam int          US_CYC    = CLK_HZ / TICK_HZ;
  localparam logic [3:0]  US_LAST   = 4'(US_CYC - 1);
  // Record layout
  localparam int          REC_LEN   = 20;
  localparam logic [4:0]  REC_LAST  = 5'h13;
  localparam logic [4:0]  HEAD_LAST = 5'h03;
  localparam int          B_SUM     = 0;
  localparam int          B_CLASS   = 1;
  localparam int          B_SPARE   = 2;
  localparam int          B_INT     = 3;
  localparam int          B_KIND    = 4;
  localparam int          B_NBIT    = 5;
  localparam int          B_NCH     = 6;
  localparam int          B_GRP     = 7;
  localparam int          B_CH0     = 8;
  localparam int          B_STAMP   = 16;
  localparam logic [4:0]  STAMP_IDX = 5'h10;
  // Constant record bytes
  localparam logic [7:0]  CLASS_VAL = 8'h15;
  localparam logic [7:0]  KIND_VAL  = 8'h73;
  localparam logic [7:0]  NBIT_VAL  = 8'h08;
  localparam logic [7:0]  NCH_VAL   = 8'h02;
  // Summary byte bits
  localparam int SUM_MOD = 0;
  localparam int SUM_INT = 1;
  localparam int SUM_EXT = 2;
  localparam int SUM_CH  = 3;
  localparam int SUM_AUX = 4;
  localparam int SUM_PAR = 7;
  // Internal byte and channel byte bits
  localparam int INT_OVF = 3;
  localparam int INT_COM = 4;
  localparam int CH_PAR  = 0;
  localparam int CH_SHT  = 3;
  // Read selectors
  localparam logic [15:0] SET_FULL  = 16'h0001;
  localparam logic [15:0] SET_HEAD  = 16'h0000;
  localparam logic [15:0] IDX_FULL  = 16'h2f01;
  localparam logic [15:0] IDX_HEAD  = 16'h2f00;
  localparam logic [15:0] IDX_BYTE  = 16'h5005;
  localparam logic [7:0]  SUB_FIRST = 8'h02;
  localparam logic [7:0]  SUB_LAST  = 8'h11;
  localparam logic [7:0]  SUB_STAMP = 8'h13;

  typedef enum logic {
    AOSD_ACC_SET,
    AOSD_ACC_INDEX
  } aosd_access_type;

  typedef struct packed {
    aosd_access_type access;
    logic [15:0]     sel;
    logic [7:0]      sub;
    logic [4:0]      offset;
  } aosd_rd_req_type;

  typedef struct packed {
    logic [7:0] data;
    logic       err;
  } aosd_rd_rsp_type;
endpackage : aosd_pkg

// file: rtl/aosd_top.sv
// Two-channel voltage output scaling and diagnostic record
//
// Contract
// - Per-channel range code; FFh disables channel
// - Code 10h: 27648 is 10 V, max 32511
// - Code 20h: 16384 is 10 V, max 20480
// - Negative words clamp to zero volts
// - No interrupt; record read only on request
// - Channel error lights LED, enters record
// - Report parameter errors; shorts only if enabled
// - Record set 01h full, 00h four bytes
// - Index 2F01h full, 2F00h head, 5005h bytes
// - Error bytes read zero without errors
// - Bits-per-channel 08h, channel kind 73h
// - Channel count byte reads two
// - Summary byte fault bits, bits 6:5 zero
// - Module class byte reads 15h
// - Internal byte: overflow bit3, comm bit4
// - Group byte: bit per channel, rest zero
// - Channel byte: parameter bit0, short bit3
// - Free 32-bit microsecond counter from zero
`timescale 1ns/100ps
`default_nettype none

module aosd_top (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Channel configuration from parameters
  input  wire logic [7:0]            range_code0_i,
  input  wire logic [7:0]            range_code1_i,
  input  wire logic [1:0]            short_en_i,
  // Output words, signed
  input  wire logic [15:0]           out_word0_i,
  input  wire logic [15:0]           out_word1_i,
  // Fault pins from the analog stage
  input  wire logic [1:0]            short_i,
  input  wire logic                  aux_miss_i,
  input  wire logic                  buf_ovf_i,
  input  wire logic                  comm_err_i,
  // Converter side
  output logic [aosd_pkg::DAC_W-1:0] dac_code0_o,
  output logic [aosd_pkg::DAC_W-1:0] dac_code1_o,
  output logic [1:0]                 dac_en_o,
  // Error LEDs
  output logic [1:0]                 ch_led_o,
  // Record read port
  input  wire logic                  rd_req_i,
  input  wire aosd_pkg::aosd_rd_req_type rd_cmd_i,
  input  wire logic                  rd_session_i,
  output logic                       rd_valid_o,
  output aosd_pkg::aosd_rd_rsp_type  rd_rsp_o
);

  // Fault pins come from the analog stage on their own timing, so each
  // one passes two flip-flops before any decode reads it. This costs two
  // cycles of latency on every fault bit, which is far below the
  // microsecond resolution of the timestamp.
  // Synchroniser stages for the fault pins
  logic [4:0] pin_meta_q;
  logic [4:0] pin_sync_q;
  wire  [4:0] pin_raw = {comm_err_i, buf_ovf_i, aux_miss_i, short_i};

  // Both stages: first feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_q <= 5'h00;
      pin_sync_q <= 5'h00;
    end else begin
      pin_meta_q <= pin_raw;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Synchronised fault levels
  wire [1:0] short_s   = pin_sync_q[1:0];
  wire       aux_s     = pin_sync_q[2];
  wire       ovf_s     = pin_sync_q[3];
  wire       com_s     = pin_sync_q[4];

  // Range code checks per channel
  wire [7:0] code [2];
  assign code[0] = range_code0_i;
  assign code[1] = range_code1_i;

  wire [15:0] word [2];
  assign word[0] = out_word0_i;
  assign word[1] = out_word1_i;

  // Converter width, local copy for part-selects below
  localparam int DAC_W_L = aosd_pkg::DAC_W;

  // Scaled code per channel, computed combinationally
  // The product is cut to the converter width on purpose; the gain is
  // chosen so that the accepted ceiling never overflows twelve bits.
  logic [DAC_W_L-1:0] scaled [2];

  logic [1:0] ch_on;
  logic [1:0] par_err;

  // Scaling: clamp, then multiply by gain
  always_comb begin
    logic [15:0] lim;
    logic [15:0] gain;
    logic [15:0] clip;
    logic [31:0] prod;
    lim  = 16'h0000;
    gain = 16'h0000;
    clip = 16'h0000;
    prod = 32'h0000_0000;
    for (int c = 0; c < 2; c++) begin
      ch_on[c]   = 1'b1;
      par_err[c] = 1'b0;
      // Select format by code
      unique case (code[c])
        aosd_pkg::RANGE_WIDE: begin
          lim  = aosd_pkg::WIDE_MAX;
          gain = aosd_pkg::WIDE_GAIN;
        end
        aosd_pkg::RANGE_NARR: begin
          lim  = aosd_pkg::NARR_MAX;
          gain = aosd_pkg::NARR_GAIN;
        end
        aosd_pkg::RANGE_OFF: begin
          // Channel fully off, no error
          lim   = 16'h0000;
          gain  = 16'h0000;
          ch_on[c] = 1'b0;
        end
        default: begin
          // Unknown code is a parameter error
          lim        = 16'h0000;
          gain       = 16'h0000;
          ch_on[c]   = 1'b0;
          par_err[c] = 1'b1;
        end
      endcase
      // Negative words give zero volts
      if (word[c][15]) begin
        clip = 16'h0000;
      end else if (word[c] > lim) begin
        // Above overrange: hold at limit
        clip = lim;
      end else begin
        clip = word[c];
      end
      prod      = clip * gain;
      scaled[c] = prod[aosd_pkg::GAIN_SH +: DAC_W_L];
    end
  end

  // Converter outputs are registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dac_code0_o <= '0;
      dac_code1_o <= '0;
      dac_en_o    <= 2'b00;
    end else begin
      dac_code0_o <= scaled[0];
      dac_code1_o <= scaled[1];
      dac_en_o    <= ch_on;
    end
  end

  // Fault bits are live levels, not sticky: a fault that goes away also
  // leaves the record. The coupler must read while the fault stands.
  // Channel fault bytes; shorts only when enabled
  wire [1:0] short_rep = short_s & short_en_i;
  logic [7:0] ch_byte [2];

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      ch_byte[c]                   = 8'h00;
      ch_byte[c][aosd_pkg::CH_PAR] = par_err[c];
      ch_byte[c][aosd_pkg::CH_SHT] = short_rep[c];
    end
  end

  // Group byte: one bit per channel
  wire [1:0] grp_bits = {|ch_byte[1], |ch_byte[0]};
  wire [7:0] grp_byte = {6'h00, grp_bits};

  // Internal fault byte
  logic [7:0] int_byte;
  always_comb begin
    int_byte                    = 8'h00;
    int_byte[aosd_pkg::INT_OVF] = ovf_s;
    int_byte[aosd_pkg::INT_COM] = com_s;
  end

  // Summary byte
  logic [7:0] sum_byte;
  always_comb begin
    sum_byte                    = 8'h00;
    sum_byte[aosd_pkg::SUM_INT] = |int_byte;
    sum_byte[aosd_pkg::SUM_EXT] = aux_s | (|short_rep);
    sum_byte[aosd_pkg::SUM_CH]  = |grp_bits;
    sum_byte[aosd_pkg::SUM_AUX] = aux_s;
    sum_byte[aosd_pkg::SUM_PAR] = |par_err;
    sum_byte[aosd_pkg::SUM_MOD] = |sum_byte[7:1];
  end

  // Error LEDs, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch_led_o <= 2'b00;
    end else begin
      ch_led_o <= grp_bits;
    end
  end

  // The prescaler divides the system clock down to one pulse each
  // microsecond; the counter only moves on that pulse, so one clock
  // drives everything and no second domain appears.
  // Microsecond prescaler and counter
  logic [3:0]  pre_q;
  logic [31:0] us_q;
  wire         us_tick = (pre_q == aosd_pkg::US_LAST);

  // Counter wraps naturally at 2^32
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q <= 4'h0;
      us_q  <= 32'h0000_0000;
    end else begin
      pre_q <= us_tick ? 4'h0 : pre_q + 4'h1;
      if (us_tick) begin
        us_q <= us_q + 32'h0000_0001;
      end
    end
  end

  // An event is any record fault bit rising. Bits that fall are not
  // events, so clearing a fault keeps the stamp of the last onset.
  // Event detection on newly set fault bits
  wire [23:0] flags = {sum_byte, int_byte, ch_byte[1]};
  wire [31:0] all_f = {flags, ch_byte[0]};
  logic [31:0] prev_f_q;
  wire         new_ev = |(all_f & ~prev_f_q);

  // Timestamp and a pending event held off by a read
  logic [31:0] stamp_q;
  logic        pend_q;

  // A session freezes the stamp; the event waits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_f_q <= 32'h0000_0000;
      stamp_q  <= 32'h0000_0000;
      pend_q   <= 1'b0;
    end else begin
      prev_f_q <= all_f;
      if (rd_session_i) begin
        // Keep stamp stable, remember event
        pend_q <= pend_q | new_ev;
      end else if (new_ev || pend_q) begin
        stamp_q <= us_q;
        pend_q  <= 1'b0;
      end
    end
  end

  // The record is built combinationally from live bytes and the held
  // stamp; reads pick one byte of it, so no copy of the record is kept.
  // Record image as bytes
  logic [7:0] rec [aosd_pkg::REC_LEN];
  always_comb begin
    for (int b = 0; b < aosd_pkg::REC_LEN; b++) begin
      rec[b] = 8'h00;
    end
    rec[aosd_pkg::B_SUM]   = sum_byte;
    rec[aosd_pkg::B_CLASS] = aosd_pkg::CLASS_VAL;
    rec[aosd_pkg::B_SPARE] = 8'h00;
    rec[aosd_pkg::B_INT]   = int_byte;
    rec[aosd_pkg::B_KIND]  = aosd_pkg::KIND_VAL;
    rec[aosd_pkg::B_NBIT]  = aosd_pkg::NBIT_VAL;
    rec[aosd_pkg::B_NCH]   = aosd_pkg::NCH_VAL;
    rec[aosd_pkg::B_GRP]   = grp_byte;
    rec[aosd_pkg::B_CH0]   = ch_byte[0];
    rec[aosd_pkg::B_CH0+1] = ch_byte[1];
    // Stamp, low byte first
    for (int k = 0; k < 4; k++) begin
      rec[aosd_pkg::B_STAMP+k] = stamp_q[8*k +: 8];
    end
  end

  // Request decode
  wire is_set = (rd_cmd_i.access == aosd_pkg::AOSD_ACC_SET);
  wire is_idx = (rd_cmd_i.access == aosd_pkg::AOSD_ACC_INDEX);
  wire [15:0] sel = rd_cmd_i.sel;
  wire [7:0]  sub = rd_cmd_i.sub;
  wire [4:0]  off = rd_cmd_i.offset;

  // Whole-record and four-byte selectors
  wire want_full = (is_set && sel == aosd_pkg::SET_FULL)
                || (is_idx && sel == aosd_pkg::IDX_FULL);
  wire want_head = (is_set && sel == aosd_pkg::SET_HEAD)
                || (is_idx && sel == aosd_pkg::IDX_HEAD);
  wire want_byte = is_idx && sel == aosd_pkg::IDX_BYTE;

  // Subindex to byte position
  wire sub_plain = (sub >= aosd_pkg::SUB_FIRST)
                && (sub <= aosd_pkg::SUB_LAST);
  wire sub_stamp = (sub == aosd_pkg::SUB_STAMP);
  wire [7:0] sub_rel = sub - aosd_pkg::SUB_FIRST;

  logic [4:0] pos;
  logic       ok;

  // Select position and legality
  always_comb begin
    pos = off;
    ok  = 1'b0;
    if (want_full) begin
      ok = (off <= aosd_pkg::REC_LAST);
    end else if (want_head) begin
      ok = (off <= aosd_pkg::HEAD_LAST);
    end else if (want_byte && sub_plain) begin
      pos = sub_rel[4:0];
      ok  = 1'b1;
    end else if (want_byte && sub_stamp) begin
      // Offset picks one stamp byte
      pos = aosd_pkg::STAMP_IDX + {3'b000, off[1:0]};
      ok  = (off <= aosd_pkg::HEAD_LAST);
    end
  end

  // Refused reads answer with zero data and the error flag set, so the
  // coupler never sees a stale byte from an earlier request.
  // Answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_valid_o    <= 1'b0;
      rd_rsp_o.data <= 8'h00;
      rd_rsp_o.err  <= 1'b0;
    end else begin
      rd_valid_o <= rd_req_i;
      if (rd_req_i) begin
        rd_rsp_o.data <= ok ? rec[pos] : 8'h00;
        rd_rsp_o.err  <= ~ok;
      end
    end
  end

endmodule : aosd_top

`default_nettype wire

// file: tb/aosd_top_asserts.sv
// Port assertions for the output scaling and record block
`timescale 1ns/100ps
`default_nettype none
module aosd_top_asserts (
  // Clock and reset
  input wire logic                        clk_i,
  input wire logic                        rst_i,
  // Causes
  input wire logic [7:0]                  range_code0_i,
  input wire logic [15:0]                 out_word0_i,
  input wire logic [1:0]                  short_en_i,
  input wire logic [1:0]                  short_i,
  input wire logic                        rd_req_i,
  input wire aosd_pkg::aosd_rd_req_type   rd_cmd_i,
  // Effects
  input wire logic [aosd_pkg::DAC_W-1:0]  dac_code0_o,
  input wire logic [1:0]                  dac_en_o,
  input wire logic [1:0]                  ch_led_o,
  input wire logic                        rd_valid_o,
  input wire aosd_pkg::aosd_rd_rsp_type   rd_rsp_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Format decode for channel 0
  wire wide = range_code0_i == aosd_pkg::RANGE_WIDE;
  wire narr = range_code0_i == aosd_pkg::RANGE_NARR;
  // Words above the accepted ceiling of each format
  wire wide_ov = wide && $signed(out_word0_i) > $signed(aosd_pkg::WIDE_MAX);
  wire narr_ov = narr && $signed(out_word0_i) > $signed(aosd_pkg::NARR_MAX);
  // Request decode for refused selectors
  wire set_bad = rd_req_i && rd_cmd_i.access == aosd_pkg::AOSD_ACC_SET &&
                 rd_cmd_i.sel > aosd_pkg::SET_FULL;
  wire head_bad = rd_req_i && rd_cmd_i.access == aosd_pkg::AOSD_ACC_INDEX &&
                  rd_cmd_i.sel == aosd_pkg::IDX_HEAD && rd_cmd_i.offset > 3;

  a_answer_next: assert property (rd_req_i |=> rd_valid_o)
    else $error("no answer one cycle after a read request");
  a_no_unasked: assert property (!rd_req_i |=> !rd_valid_o)
    else $error("answer given without a request");
  a_bad_set: assert property (set_bad |=> rd_rsp_o == 9'h001)
    else $error("unknown record set not refused");
  a_head_limit: assert property (head_bad |=> rd_rsp_o.err)
    else $error("head index read past four bytes");
  a_off_disable: assert property (range_code0_i == 8'hff |=> !dac_en_o[0])
    else $error("channel left on under the off code");
  a_neg_clamp: assert property (wide && out_word0_i[15] |=> dac_code0_o == '0)
    else $error("negative word not held at zero");
  a_wide_ceiling: assert property (wide_ov |=> dac_code0_o == 12'hf0c)
    else $error("wide format not held at its ceiling");
  a_narr_ceiling: assert property (narr_ov |=> dac_code0_o == 12'hfff)
    else $error("narrow format not held at its ceiling");
  a_short_led: assert property ((short_en_i[0] && short_i[0]) [*4] |-> ch_led_o[0])
    else $error("enabled short did not light the LED");

  c_refused: cover property (rd_req_i ##1 rd_rsp_o.err);
  c_led_one: cover property (ch_led_o[1]);
  c_both_on: cover property (dac_en_o == 2'b11);
endmodule : aosd_top_asserts

bind aosd_top aosd_top_asserts chk_u (.clk_i, .rst_i, .range_code0_i,
  .out_word0_i, .short_en_i, .short_i, .rd_req_i, .rd_cmd_i, .dac_code0_o,
  .dac_en_o, .ch_led_o, .rd_valid_o, .rd_rsp_o);
`default_nettype wire

// file: tb/aosd_coupler.sv
// Coupler model that reads the diagnostic record
`timescale 1ns/100ps
`default_nettype none
module aosd_coupler (
  // Clock
  input  wire logic                      clk_i,
  // Read port towards the block
  output logic                           rd_req_o,
  output aosd_pkg::aosd_rd_req_type      rd_cmd_o,
  output logic                           rd_session_o,
  input  wire logic                      rd_valid_i,
  input  wire aosd_pkg::aosd_rd_rsp_type rd_rsp_i
);
  // Idle from time zero
  initial begin
    rd_req_o = 1'b0;
    rd_cmd_o = '0;
    rd_session_o = 1'b0;
  end

  // Session level freezes the stamp while a record is read
  task automatic session(input logic on);
    rd_session_o <= on;
  endtask : session

  // One read after gap idle cycles; request is a one-cycle pulse
  task automatic fetch(input aosd_pkg::aosd_rd_req_type c, input int gap,
                       output aosd_pkg::aosd_rd_rsp_type r);
    int n;
    n = 0;
    repeat (gap) @(posedge clk_i);
    rd_req_o <= 1'b1;
    rd_cmd_o <= c;
    @(posedge clk_i);
    rd_req_o <= 1'b0;
    // Released lines show junk so a stale command cannot pass
    rd_cmd_o <= ~c;
    do begin
      @(posedge clk_i);
      n++;
    end while (rd_valid_i !== 1'b1 && n < 4);
    r = rd_rsp_i;
  endtask : fetch
endmodule : aosd_coupler
`default_nettype wire

// file: tb/aosd_top_bench.sv
// Self-checking bench for the output scaling and record block
`timescale 1ns/100ps
`default_nettype none
module aosd_top_bench;
  // Stimulus, all driven on the rising edge
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  code0 = 8'h10;   // Legal codes avoid a start-up error
  logic [7:0]  code1 = 8'h10;
  logic [15:0] word0 = '0;
  logic [15:0] word1 = '0;
  logic [1:0]  sen = '0;        // Short recognition enables
  logic [1:0]  sht = '0;        // Short pins
  logic [2:0]  pins = '0;       // Aux missing, overflow, comm error
  // Outputs and read port
  logic [11:0] dac0;
  logic [11:0] dac1;
  logic [1:0]  en;
  logic [1:0]  led;
  logic        req;
  logic        sess;
  logic        vld;
  aosd_pkg::aosd_rd_req_type cmd;
  aosd_pkg::aosd_rd_rsp_type rsp;
  // Counters and expected record
  int          fail_count = 0;
  int          compares = 0;
  int          cyc = 0;
  int          rel = 0;         // Cycles since reset release
  logic [7:0]  base [20] = '{1:8'h15, 4:8'h73, 5:8'h08, 6:8'h02,
                             default:8'h00};
  // Range code, word, expected converter code
  logic [35:0] dtab [10] = '{36'h10_3600_665, 36'h10_6c00_ccb,
    36'h10_7eff_f0c, 36'h10_7fff_f0c, 36'h10_ffff_000, 36'h20_2000_666,
    36'h20_4000_ccc, 36'h20_5000_fff, 36'h20_7530_fff, 36'hff_4000_000};
  // Pins, internal byte, summary byte
  logic [19:0] ptab [3] = '{20'h1_10_03, 20'h2_08_03, 20'h4_00_15};

  always #50 clk_i = ~clk_i;

  // Cycle count; a hang ends the run as a failure
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    rel <= rst_i ? 0 : rel + 1;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  aosd_top dut_u (.clk_i, .rst_i, .range_code0_i(code0),
    .range_code1_i(code1), .short_en_i(sen), .out_word0_i(word0),
    .out_word1_i(word1), .short_i(sht), .aux_miss_i(pins[2]),
    .buf_ovf_i(pins[1]), .comm_err_i(pins[0]), .dac_code0_o(dac0),
    .dac_code1_o(dac1), .dac_en_o(en), .ch_led_o(led), .rd_req_i(req),
    .rd_cmd_i(cmd), .rd_session_i(sess), .rd_valid_o(vld), .rd_rsp_o(rsp));
  aosd_coupler cpl_u (.clk_i, .rd_req_o(req), .rd_cmd_o(cmd),
    .rd_session_o(sess), .rd_valid_i(vld), .rd_rsp_i(rsp));

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  task automatic chk(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Expected {data, err}: refused reads give zero data and err
  function automatic logic [8:0] ex(input bit ok, input int k);
    return ok ? {base[k % 20], 1'b0} : 9'h001;
  endfunction : ex

  // Odd offsets wait a cycle, even ones go back to back
  task automatic rchk(input string what, input logic a, input logic [15:0] s,
                      input logic [7:0] sb, input int o, input logic [8:0] e);
    aosd_pkg::aosd_rd_rsp_type r;
    cpl_u.fetch('{aosd_pkg::aosd_access_type'(a), s, sb, 5'(o)}, o % 2, r);
    chk(what, 32'(r), 32'(e));
  endtask : rchk

  // Every route to every byte agrees with the expected record
  task automatic sweep();
    for (int i = 0; i < 20; i++) begin
      rchk("set01", 0, 16'h0001, 0, i, ex(1, i));
      rchk("set00", 0, 16'h0000, 0, i, ex(i < 4, i));
      rchk("ix2f01", 1, 16'h2f01, 0, i, ex(1, i));
      rchk("ix2f00", 1, 16'h2f00, 0, i, ex(i < 4, i));
      rchk("sub", 1, 16'h5005, 8'(i + 2), 0,
           ex(i != 16 && i < 18, i == 17 ? 16 : i));
      rchk("stamp", 1, 16'h5005, 8'h13, i, ex(i < 4, i + 16));
    end
    rchk("set02", 0, 16'h0002, 0, 0, 9'h001);
    rchk("sub01", 1, 16'h5005, 8'h01, 0, 9'h001);
  endtask : sweep

  aosd_pkg::aosd_rd_rsp_type rsp_hold;

  // Stamp must lie near the event; it then stays the expected value
  task automatic capture(input int t);
    logic [31:0] s;
    for (int k = 0; k < 4; k++) begin
      cpl_u.fetch('{aosd_pkg::AOSD_ACC_SET, 16'h0001, 8'h00, 5'(16 + k)},
                  0, rsp_hold);
      s[8*k +: 8] = rsp_hold.data;
    end
    chk("stamp time", 32'(s >= t / 10 - 1 && s <= t / 10 + 2), 1);
    for (int k = 0; k < 4; k++) begin
      base[16 + k] = s[8*k +: 8];
    end
  endtask : capture

  task automatic clean();
    base[0] = 8'h00;
    for (int k = 7; k < 10; k++) begin
      base[k] = 8'h00;
    end
  endtask : clean

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    tick(8);
    rst_i <= 1'b0;
    tick(2);
    sweep();
    // Scaling, ceilings, clamp and the off code on both channels
    foreach (dtab[i]) begin
      {code0, word0} <= dtab[i][35:12];
      {code1, word1} <= dtab[i][35:12];
      tick(3);
      chk("enable", 32'(en), {30'h0, {2{dtab[i][35:28] != 8'hff}}});
      if (dtab[i][35:28] != 8'hff) begin
        chk("dac0", 32'(dac0), 32'(dtab[i][11:0]));
        chk("dac1", 32'(dac1), 32'(dtab[i][11:0]));
      end
    end
    code0 <= 8'h10;
    code1 <= 8'h33;
    tick(6);
    chk("led", 32'(led), 32'h2);
    chk("enable", 32'(en), 32'h1);
    base[0] = 8'h89;
    base[7] = 8'h02;
    base[9] = 8'h01;
    capture(rel - 6);
    sweep();
    // Short with recognition off must stay silent
    code1 <= 8'h10;
    sht <= 2'b01;
    tick(6);
    clean();
    rchk("masked", 0, 16'h0001, 0, 8, 9'h000);
    chk("led", 32'(led), 32'h0);
    sen <= 2'b01;
    tick(6);
    chk("led", 32'(led), 32'h1);
    base[0] = 8'h0d;
    base[7] = 8'h01;
    base[8] = 8'h08;
    capture(rel - 6);
    sweep();
    sht <= 2'b00;
    tick(6);
    clean();
    foreach (ptab[i]) begin
      pins <= ptab[i][18:16];
      tick(6);
      capture(rel - 6);
      rchk("summary", 0, 16'h0000, 0, 0, {ptab[i][7:0], 1'b0});
      rchk("internal", 0, 16'h0000, 0, 3, {ptab[i][15:8], 1'b0});
    end
    // An event during a read session waits until the session ends
    pins <= 3'b000;
    tick(6);
    cpl_u.session(1'b1);
    pins <= 3'b010;
    tick(30);
    for (int k = 16; k < 20; k++) begin
      rchk("held", 0, 16'h0001, 0, k, ex(1, k));
    end
    cpl_u.session(1'b0);
    tick(6);
    capture(rel - 6);
    give_verdict();
  end
endmodule : aosd_top_bench
`default_nettype wire
